//--- include/usb_irq_params.svh
// Constants for the USB event interrupt masking block
// How it works
// [RULE_01] An event interrupts only while its matching enable bit is 1.
// [RULE_02] The 8-bit enable register at index FFFDh resets to 0; bit 1 reads 0.
// [RULE_03] Enable bit 6 lets the suspend event interrupt.
// [RULE_04] Enable bit 5 lets the resume event interrupt.
// [RULE_05] A setup buffer over-write sets a read-only over-write flag.
// [RULE_06] A completed setup stage sets a read-only flag, cleared by a vector write.
// [RULE_07] Enable bit 4 lets the start-of-frame event interrupt.
// [RULE_08] Enable bit 0 lets the setup over-write event interrupt.
`ifndef USB_IRQ_PARAMS_SVH
`define USB_IRQ_PARAMS_SVH
`define IEN_INDEX 16'hFFFD
`define STAT_INDEX 16'hFFFE
`define VEC_INDEX 16'hFFF0
`define IEN_RESET 8'h00
`define IEN_WMASK 8'hFD
`define BIT_BUS_RESET 7
`define BIT_SUSPEND 6
`define BIT_RESUME 5
`define BIT_FRAME 4
`define BIT_SYNTH_FRAME 3
`define BIT_SETUP 2
`define BIT_OVERWRITE 0
`define SW_CLEAR_MASK 8'hF8
`define VEC_CLEAR_MASK 8'h05
`endif

//--- include/usb_irq_pkg.sv
// Types for the USB event interrupt masking block
package usb_irq_pkg;
  typedef logic [7:0] evt_t;
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [17:0] addr;
    logic [31:0] wdata;
  } apb_req_s;
endpackage

//--- design/usb_event_irq_mask.sv
// APB-mapped USB event status, enable mask and interrupt output
`timescale 1ns/10ps
`include "usb_irq_params.svh"
module usb_event_irq_mask #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Event pulses from the USB engine, same clock
  input wire logic [7:0] EVT_I,
  // Interrupt request
  output logic IRQ_O
);
  usb_irq_pkg::apb_req_s req;
  usb_irq_pkg::evt_t ien_reg, ien_next;
  usb_irq_pkg::evt_t stat_reg, stat_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic irq_reg, irq_next;
  logic setup_ph, access, wr;
  logic hit_ien, hit_stat, hit_vec;
  usb_irq_pkg::evt_t clr, set;

  assign req = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I[17:0], PWDATA_I};
  assign setup_ph = req.sel && !req.enable;
  assign access = req.sel && req.enable;
  assign wr = access && req.write;
  // Word aligned index is byte address over four
  assign hit_ien = req.addr == {`IEN_INDEX, 2'b00};
  assign hit_stat = req.addr == {`STAT_INDEX, 2'b00};
  assign hit_vec = req.addr == {`VEC_INDEX, 2'b00};

  // Zero wait states keep the core simple
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && err_reg;
  assign PRDATA_O = rdata_reg;
  assign IRQ_O = irq_reg;

  always_comb begin
    ien_next = ien_reg;
    if (wr && hit_ien) begin
      ien_next = req.wdata[7:0] & `IEN_WMASK; // [RULE_02]
    end
    // Bit 1 is not an event source
    set = EVT_I & `IEN_WMASK; // [RULE_05] [RULE_06]
    clr = 8'h00;
    if (wr && hit_stat) begin
      clr = req.wdata[7:0] & `SW_CLEAR_MASK;
    end
    if (wr && hit_vec) begin
      clr = clr | `VEC_CLEAR_MASK; // [RULE_06]
    end
    // Set beats clear so no event is lost
    stat_next = (stat_reg & ~clr) | set;
    irq_next = |(stat_next & ien_next); // [RULE_01] [RULE_03] [RULE_04]
    // Frame and over-write sources share the same gate [RULE_07] [RULE_08]
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup_ph) begin
      err_next = !(hit_ien || hit_stat || hit_vec);
      rdata_next = 32'h0000_0000;
      if (hit_ien) begin
        rdata_next = {24'h00_0000, ien_reg}; // [RULE_02]
      end else if (hit_stat) begin
        rdata_next = {24'h00_0000, stat_reg};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ien_reg <= `IEN_RESET;
      stat_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ien_reg <= ien_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      irq_reg <= irq_next;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence ien_write_s;
    wr && hit_ien;
  endsequence

  AST_MASK_GATES: assert property ( // [RULE_01]
    IRQ_O |-> |($past(stat_next) & $past(ien_next)))
    else $error("Interrupt raised without an enabled event");

  AST_RESERVED_ZERO: assert property ( // [RULE_02]
    ien_reg[1] == 1'b0)
    else $error("Reserved enable bit is not zero");

  AST_IEN_WRITE: assert property ( // [RULE_02]
    ien_write_s |=> ien_reg == ($past(req.wdata[7:0]) & `IEN_WMASK))
    else $error("Enable register did not take the written value");

  AST_SUSPEND_EN: assert property ( // [RULE_03]
    ien_reg[`BIT_SUSPEND] && EVT_I[`BIT_SUSPEND] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled suspend event gave no interrupt");

  AST_RESUME_EN: assert property ( // [RULE_04]
    ien_reg[`BIT_RESUME] && EVT_I[`BIT_RESUME] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled resume event gave no interrupt");

  AST_OVERWRITE_SET: assert property ( // [RULE_05]
    EVT_I[`BIT_OVERWRITE] |=> stat_reg[`BIT_OVERWRITE])
    else $error("Over-write flag not set");

  AST_SETUP_CLEAR: assert property ( // [RULE_06]
    wr && hit_vec && !EVT_I[`BIT_SETUP] |=> !stat_reg[`BIT_SETUP])
    else $error("Setup flag not cleared by vector write");

  AST_SETUP_STICKY: assert property ( // [RULE_06]
    stat_reg[`BIT_SETUP] && !(wr && hit_vec) |=> stat_reg[`BIT_SETUP])
    else $error("Setup flag dropped without vector write");

  AST_FRAME_EN: assert property ( // [RULE_07]
    ien_reg[`BIT_FRAME] && EVT_I[`BIT_FRAME] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled frame event gave no interrupt");

  AST_OVERWRITE_EN: assert property ( // [RULE_08]
    ien_reg[`BIT_OVERWRITE] && EVT_I[`BIT_OVERWRITE] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled over-write event gave no interrupt");

  sequence vec_write_s;
    wr && hit_vec;
  endsequence

  sequence stat_write_s;
    wr && hit_stat;
  endsequence

  sequence ien_read_s;
    setup_ph && hit_ien ##1 access;
  endsequence

  sequence stat_read_s;
    setup_ph && hit_stat ##1 access;
  endsequence

  sequence vec_read_s;
    setup_ph && hit_vec ##1 access;
  endsequence

  sequence stray_access_s;
    setup_ph && !(hit_ien || hit_stat || hit_vec) ##1 access;
  endsequence

  AST_BUS_RESET_EN: assert property ( // [RULE_01]
    ien_reg[`BIT_BUS_RESET] && EVT_I[`BIT_BUS_RESET] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled bus reset event gave no interrupt");

  AST_SYNTH_FRAME_EN: assert property ( // [RULE_01]
    ien_reg[`BIT_SYNTH_FRAME] && EVT_I[`BIT_SYNTH_FRAME] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled synthetic frame event gave no interrupt");

  AST_SETUP_EN: assert property ( // [RULE_01]
    ien_reg[`BIT_SETUP] && EVT_I[`BIT_SETUP] && !(wr && hit_ien)
    |=> IRQ_O)
    else $error("Enabled setup event gave no interrupt");

  AST_QUIET_MASKED: assert property ( // [RULE_01]
    (stat_reg & ien_reg) == 8'h00 && (EVT_I & ien_reg) == 8'h00
    && !(wr && hit_ien) |=> !IRQ_O)
    else $error("Interrupt raised with every source masked");

  AST_IRQ_FOLLOWS: assert property ( // [RULE_01]
    IRQ_O
    |-> (stat_reg & ien_reg) != 8'h00)
    else $error("Interrupt without a pending enabled flag");

  AST_IRQ_LOW_OFF: assert property ( // [RULE_01]
    ien_reg == 8'h00
    |-> !IRQ_O)
    else $error("Interrupt raised with the mask all clear");

  AST_IEN_HOLD: assert property ( // [RULE_02]
    !(wr && hit_ien)
    |=> $stable(ien_reg))
    else $error("Enable register changed without a write");

  AST_IEN_READ: assert property ( // [RULE_02]
    ien_read_s
    |-> PRDATA_O == {24'h00_0000, $past(ien_reg)})
    else $error("Enable register read back wrong");

  AST_STAT_READ: assert property ( // [RULE_05]
    stat_read_s
    |-> PRDATA_O == {24'h00_0000, $past(stat_reg)})
    else $error("Status register read back wrong");

  AST_VEC_READ_ZERO: assert property ( // [RULE_06]
    vec_read_s
    |-> PRDATA_O == 32'h0000_0000 && !PSLVERR_O)
    else $error("Vector register read not zero");

  AST_STRAY_ERR: assert property ( // [RULE_02]
    stray_access_s
    |-> PSLVERR_O && PRDATA_O == 32'h0000_0000)
    else $error("Unmapped access not refused");

  AST_ERR_IN_ACCESS: assert property ( // [RULE_02]
    PSLVERR_O
    |-> access)
    else $error("Error response outside an access phase");

  AST_READY: assert property ( // [RULE_02]
    access
    |-> PREADY_O)
    else $error("Slave inserted a wait state");

  AST_UPPER_ZERO: assert property ( // [RULE_02]
    access
    |-> PRDATA_O[31:8] == 24'h00_0000)
    else $error("Upper read data not zero");

  AST_STAT_BIT1_ZERO: assert property ( // [RULE_02]
    access
    |-> !stat_reg[1])
    else $error("Reserved status bit set");

  AST_OVERWRITE_STICKY: assert property ( // [RULE_05]
    stat_reg[`BIT_OVERWRITE] && !(wr && hit_vec)
    |=> stat_reg[`BIT_OVERWRITE])
    else $error("Over-write flag dropped without vector write");

  AST_OVERWRITE_CLEAR: assert property ( // [RULE_05]
    vec_write_s ##0 !EVT_I[`BIT_OVERWRITE]
    |=> !stat_reg[`BIT_OVERWRITE])
    else $error("Over-write flag not cleared by vector write");

  AST_STAT_WRITE_LOW: assert property ( // [RULE_05]
    stat_write_s
    |=> stat_reg[0] == ($past(stat_reg[0]) || $past(EVT_I[0])))
    else $error("Status write touched the over-write flag");

  AST_SETUP_SET: assert property ( // [RULE_06]
    EVT_I[`BIT_SETUP]
    |=> stat_reg[`BIT_SETUP])
    else $error("Setup flag not set");

  AST_SET_WINS: assert property ( // [RULE_01]
    stat_write_s ##0 (EVT_I[`BIT_BUS_RESET] && req.wdata[`BIT_BUS_RESET])
    |=> stat_reg[`BIT_BUS_RESET])
    else $error("Clear beat a same-cycle event");

  AST_STAT_CLEAR: assert property ( // [RULE_01]
    stat_write_s ##0 (req.wdata[`BIT_BUS_RESET] && !EVT_I[`BIT_BUS_RESET])
    |=> !stat_reg[`BIT_BUS_RESET])
    else $error("Status write did not clear the flag");

  AST_SUSPEND_SET: assert property ( // [RULE_03]
    EVT_I[`BIT_SUSPEND]
    |=> stat_reg[`BIT_SUSPEND])
    else $error("Suspend flag not set");

  AST_RESUME_SET: assert property ( // [RULE_04]
    EVT_I[`BIT_RESUME]
    |=> stat_reg[`BIT_RESUME])
    else $error("Resume flag not set");

  AST_FRAME_SET: assert property ( // [RULE_07]
    EVT_I[`BIT_FRAME]
    |=> stat_reg[`BIT_FRAME])
    else $error("Frame flag not set");

  AST_BUS_RESET_SET: assert property ( // [RULE_01]
    EVT_I[`BIT_BUS_RESET]
    |=> stat_reg[`BIT_BUS_RESET])
    else $error("Bus reset flag not set");

  // One pair of checks per event source; bit 1 has none
  for (genvar b = 0; b < 8; b++) begin : g_evt
    if (b != 1) begin : g_src
      AST_EVT_FLAG: assert property ( // [RULE_01]
        EVT_I[b]
        |=> stat_reg[b])
        else $error("Event did not set its status flag");

      AST_EVT_IRQ: assert property ( // [RULE_01]
        ien_reg[b] && EVT_I[b] && !(wr && hit_ien)
        |=> IRQ_O)
        else $error("Enabled event gave no interrupt");
    end
  end

endmodule // usb_event_irq_mask

//--- test/usb_event_irq_mask_test.sv
// Self-checking bench for the USB event interrupt masking block
`timescale 1ns/10ps
module usb_event_irq_mask_test;
  localparam logic [17:0] IEN = 18'h3FFF4;
  localparam logic [17:0] STA = 18'h3FFF8;
  localparam logic [17:0] VEC = 18'h3FFC0;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pw = 0;
  logic [17:0] pa = '0;
  logic [31:0] pwd = '0;
  logic [7:0] evt = '0;
  logic [31:0] prd;
  logic rdy, err, irq;
  logic [7:0] v;
  logic [32:0] q[$];
  int fails = 0;
  int checked = 0;
  int bits[7] = '{7, 6, 5, 4, 3, 2, 0};
  usb_event_irq_mask usb_event_irq_mask_inst (.CLK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw), .PADDR_I(pa),
    .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .EVT_I(evt), .IRQ_O(irq));
  initial forever #2.5 clk = ~clk;
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Request held until pready seen high at an edge
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (!rdy);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  // Expected {pslverr, prdata} noted before the read goes out
  task rd(input logic [17:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task pulse(input logic [7:0] m);
    evt <= m;
    @(posedge clk);
    evt <= 8'h00;
    @(posedge clk);
  endtask
  // Sampled past the edge so the registered level has landed
  task ci(input logic x);
    #1;
    cmp({32'h0, irq}, {32'h0, x});
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (psel && pen && rdy && !pw && q.size() > 0) cmp({err, prd}, q.pop_front());
  initial begin
    #20000;
    fails++;
    close_out;
  end
  initial begin
    void'($urandom(32'h01CC8B0D));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(IEN, 33'h0);
    rd(18'h3FFF0, 33'h100000000);
    v = 8'($urandom);
    apb(1, IEN, {24'h0, v});
    rd(IEN, {25'h0, v & 8'hFD});
    apb(1, IEN, 32'hFF);
    rd(IEN, 33'hFD);
    apb(1, IEN, 32'h0);
    pulse(8'hFF);
    ci(0);
    rd(STA, 33'hFD);
    apb(1, VEC, 32'h0);
    rd(STA, 33'hF8);
    apb(1, STA, 32'hF8);
    foreach (bits[i]) begin
      apb(1, IEN, 32'h1 << bits[i]);
      pulse(~(8'h01 << bits[i]));
      ci(0);
      pulse(8'h01 << bits[i]);
      ci(1);
      apb(1, STA, 32'hF8);
      apb(1, VEC, 32'h0);
      ci(0);
    end
    close_out;
  end
endmodule // usb_event_irq_mask_test
